//--- xdc_pkg.sv
package xdc_pkg;

  localparam int CODE_W = 10;
  localparam int DET_W  = 7;
  localparam int AXI_AW = 8;
  localparam int NSRC   = 4;

  localparam logic [CODE_W-1:0] CODE_MAX = 10'h3ff;

  // Register byte offsets
  localparam logic [AXI_AW-1:0] OFS_X_POS = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_X_NEG = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_Y_POS = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_Y_NEG = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_X_DET = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_Y_DET = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_CTRL  = 8'h18;
  localparam logic [AXI_AW-1:0] OFS_STAT  = 8'h1c;

  // Register indices after decode
  localparam logic [3:0] REG_X_POS = 4'h0;
  localparam logic [3:0] REG_X_NEG = 4'h1;
  localparam logic [3:0] REG_Y_POS = 4'h2;
  localparam logic [3:0] REG_Y_NEG = 4'h3;
  localparam logic [3:0] REG_X_DET = 4'h4;
  localparam logic [3:0] REG_Y_DET = 4'h5;
  localparam logic [3:0] REG_CTRL  = 4'h6;
  localparam logic [3:0] REG_STAT  = 4'h7;
  localparam logic [3:0] REG_NONE  = 4'hf;

  // Field positions
  localparam int DET_DIR_BIT    = 6;
  localparam int DET_MAG_W      = 6;
  localparam int DET_STEP_SHIFT = 3;
  localparam int CTRL_ST_BIT    = 0;
  localparam int CTRL_SCAN_BIT  = 1;
  localparam int CTRL_SEL_LSB   = 2;
  localparam int STAT_SEL_LSB   = 10;

  // Reset values
  localparam logic [CODE_W-1:0] AMP_RST = 10'h000;
  localparam logic [DET_W-1:0]  DET_RST = 7'h00;

  // Timing
  localparam int SCAN_DWELL_CYC = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [NSRC-1:0] {
    SRC_X_POS = 4'h1,
    SRC_X_NEG = 4'h2,
    SRC_Y_POS = 4'h4,
    SRC_Y_NEG = 4'h8
  } xdc_src_e;

  typedef struct packed {
    logic             scan_en;
    logic [1:0]       man_sel;
  } xdc_scan_cfg_s;

endpackage : xdc_pkg

//--- xdc_detune.sv
`timescale 1ns/1ps
`default_nettype none
module xdc_detune
  import xdc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              enable,
  input  wire logic [CODE_W-1:0] code_in,
  input  wire logic [DET_W-1:0]  setting,
  output logic      [CODE_W-1:0] code_out
);

  localparam int EW = CODE_W + 1;

  logic [EW-1:0] mag;
  logic [EW-1:0] sum;
  logic [EW-1:0] dif;

  assign mag = EW'(setting[DET_MAG_W-1:0]) << DET_STEP_SHIFT; // [R6]
  assign sum = {1'b0, code_in} + mag;
  assign dif = {1'b0, code_in} - mag;

  always_comb begin
    if (!enable) begin
      code_out = code_in; // [R4]
    end else if (setting[DET_DIR_BIT]) begin
      // Clip rather than wrap, a wrap would swing the drive full scale
      code_out = sum[CODE_W] ? CODE_MAX : sum[CODE_W-1:0]; // [R5] [R8]
    end else begin
      code_out = dif[CODE_W] ? '0 : dif[CODE_W-1:0]; // [R5] [R8]
    end
  end

  a_bypass_plain: assert property (@(posedge clk) disable iff (rst) // [R4]
    !enable |-> code_out == code_in) else $error("detune applied while off");
  a_zero_mag: assert property (@(posedge clk) disable iff (rst) // [R6]
    enable && setting[DET_MAG_W-1:0] == '0 |-> code_out == code_in)
    else $error("zero detune changed code");
  a_add_step: assert property (@(posedge clk) disable iff (rst) // [R5]
    enable && setting[DET_DIR_BIT] && !sum[CODE_W]
    |-> EW'(code_out) == EW'(code_in) + (EW'(setting[5:0]) << 3))
    else $error("add direction wrong");
  a_sub_step: assert property (@(posedge clk) disable iff (rst) // [R5]
    enable && !setting[DET_DIR_BIT] && EW'(code_in) >= (EW'(setting[5:0]) << 3)
    |-> EW'(code_out) + (EW'(setting[5:0]) << 3) == EW'(code_in))
    else $error("subtract direction wrong");
  a_sat_high: assert property (@(posedge clk) disable iff (rst) // [R8]
    enable && setting[DET_DIR_BIT] && EW'(code_in) + (EW'(setting[5:0]) << 3) > 11'h3ff
    |-> code_out == 10'h3ff) else $error("no clip at top");
  a_sat_low: assert property (@(posedge clk) disable iff (rst) // [R8]
    enable && !setting[DET_DIR_BIT] && EW'(code_in) < (EW'(setting[5:0]) << 3)
    |-> code_out == 10'h000) else $error("no clip at zero");

endmodule : xdc_detune
`default_nettype wire

//--- xdc_scan.sv
`timescale 1ns/1ps
`default_nettype none
module xdc_scan
  import xdc_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter logic [CNT_W-1:0] DWELL = CNT_W'(SCAN_DWELL_CYC)
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire xdc_scan_cfg_s cfg,
  output logic [1:0]         src_idx
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [1:0]       idx;
  } xdc_scan_s;

  xdc_scan_s st;
  xdc_scan_s nxt;

  always_comb begin
    nxt = st;
    if (!cfg.scan_en) begin
      nxt.cnt = '0;
      nxt.idx = cfg.man_sel;
    end else if (st.cnt >= DWELL - CNT_W'(1)) begin
      // Each source holds for a full dwell so the driver can settle
      nxt.cnt = '0;
      nxt.idx = st.idx + 2'h1; // [R3]
    end else begin
      nxt.cnt = st.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  assign src_idx = st.idx;

endmodule : xdc_scan
`default_nettype wire

//--- xdc_dac_select.sv
// Notes on behaviour
// R1: Four 10-bit amplitude codes, 0 to 1023
// R2: Code 0 is highest level, 1023 zero
// R3: One shared DAC, exactly one code presented
// R4: Offset applied only when self-test set
// R5: Setting bit 6: 0 subtracts, 1 adds
// R6: Offset is bits 5:0 times eight codes
// R7: X setting for X codes, Y for Y
// R8: Out-of-range result clips to nearest limit
`timescale 1ns/1ps
`default_nettype none
module xdc_dac_select
  import xdc_pkg::*;
#(
  parameter int SCAN_CNT_W = 8
) (
  input  wire logic              MCLK,
  input  wire logic              RST,
  input  wire logic [AXI_AW-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [AXI_AW-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  output logic [CODE_W-1:0]      DAC_CODE,
  output logic [NSRC-1:0]        DAC_SEL
);

  typedef struct packed {
    logic                         awready;
    logic                         wready;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         arready;
    logic                         rvalid;
    logic [1:0]                   rresp;
    logic [31:0]                  rdata;
    logic                         aw_have;
    logic [AXI_AW-1:0]            aw_addr;
    logic                         w_have;
    logic [31:0]                  w_data;
    logic [3:0]                   w_strb;
    logic [NSRC-1:0][CODE_W-1:0]  amp;
    logic [DET_W-1:0]             det_x;
    logic [DET_W-1:0]             det_y;
    logic                         self_test;
    logic                         scan_en;
    logic [1:0]                   man_sel;
    logic [CODE_W-1:0]            dac_code;
    logic [NSRC-1:0]              dac_sel;
  } xdc_top_s;

  xdc_top_s                    st;
  xdc_top_s                    nxt;
  logic [NSRC-1:0][CODE_W-1:0] det_code;
  logic [1:0]                  src_idx;
  logic [CODE_W-1:0]           raw_sel;
  logic                        aw_hs;
  logic                        w_hs;
  logic                        ar_hs;
  logic                        wr_go;
  logic [3:0]                  wr_idx;
  logic [31:0]                 wr_val;
  xdc_scan_cfg_s               scan_cfg;

  function automatic logic [3:0] reg_index(input logic [AXI_AW-1:0] addr);
    case (addr)
      OFS_X_POS: reg_index = REG_X_POS;
      OFS_X_NEG: reg_index = REG_X_NEG;
      OFS_Y_POS: reg_index = REG_Y_POS;
      OFS_Y_NEG: reg_index = REG_Y_NEG;
      OFS_X_DET: reg_index = REG_X_DET;
      OFS_Y_DET: reg_index = REG_Y_DET;
      OFS_CTRL:  reg_index = REG_CTRL;
      OFS_STAT:  reg_index = REG_STAT;
      default:   reg_index = REG_NONE;
    endcase
  endfunction : reg_index

  function automatic logic [31:0] reg_word(input xdc_top_s s, input logic [3:0] idx);
    logic [31:0] w;
    w = '0;
    case (idx)
      REG_X_POS, REG_X_NEG, REG_Y_POS, REG_Y_NEG: begin
        w[CODE_W-1:0] = s.amp[idx[1:0]];
      end
      REG_X_DET: begin
        w[DET_W-1:0] = s.det_x;
      end
      REG_Y_DET: begin
        w[DET_W-1:0] = s.det_y;
      end
      REG_CTRL: begin
        w[CTRL_ST_BIT]                  = s.self_test;
        w[CTRL_SCAN_BIT]                = s.scan_en;
        w[CTRL_SEL_LSB +: 2]            = s.man_sel;
      end
      REG_STAT: begin
        w[CODE_W-1:0]                   = s.dac_code;
        w[STAT_SEL_LSB +: NSRC]         = s.dac_sel;
      end
      default: begin
        w = '0;
      end
    endcase
    reg_word = w;
  endfunction : reg_word

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = data[8*b +: 8];
      end
    end
    merge = m;
  endfunction : merge

  // Per-source detune, X setting on X codes, Y setting on Y codes
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_det
      xdc_detune u_det (
        .clk      (MCLK),
        .rst      (RST),
        .enable   (st.self_test),                          // [R4]
        .code_in  (st.amp[gi]),
        .setting  ((gi < 2) ? st.det_x : st.det_y),        // [R7]
        .code_out (det_code[gi])
      );
    end
  endgenerate

  assign scan_cfg.scan_en = st.scan_en;
  assign scan_cfg.man_sel = st.man_sel;

  xdc_scan #(
    .CNT_W (SCAN_CNT_W)
  ) u_scan (
    .clk     (MCLK),
    .rst     (RST),
    .cfg     (scan_cfg),
    .src_idx (src_idx)
  );

  assign raw_sel = st.amp[src_idx];
  assign aw_hs   = S_AXI_AWVALID & st.awready;
  assign w_hs    = S_AXI_WVALID & st.wready;
  assign ar_hs   = S_AXI_ARVALID & st.arready;

  always_comb begin
    nxt    = st;
    wr_go  = 1'b0;
    wr_idx = REG_NONE;
    wr_val = '0;

    // Write address and data may come in either order
    if (aw_hs) begin
      nxt.aw_have = 1'b1;
      nxt.aw_addr = S_AXI_AWADDR;
    end
    if (w_hs) begin
      nxt.w_have = 1'b1;
      nxt.w_data = S_AXI_WDATA;
      nxt.w_strb = S_AXI_WSTRB;
    end
    if (st.bvalid && S_AXI_BREADY) begin
      nxt.bvalid = 1'b0;
    end

    if (nxt.aw_have && nxt.w_have && !nxt.bvalid) begin
      wr_go       = 1'b1;
      wr_idx      = reg_index(nxt.aw_addr);
      wr_val      = merge(reg_word(st, wr_idx), nxt.w_data, nxt.w_strb);
      nxt.aw_have = 1'b0;
      nxt.w_have  = 1'b0;
      nxt.bvalid  = 1'b1;
      nxt.bresp   = RESP_OKAY;
      case (wr_idx)
        REG_X_POS, REG_X_NEG, REG_Y_POS, REG_Y_NEG: begin
          nxt.amp[wr_idx[1:0]] = wr_val[CODE_W-1:0]; // [R1]
        end
        REG_X_DET: begin
          nxt.det_x = wr_val[DET_W-1:0];
        end
        REG_Y_DET: begin
          nxt.det_y = wr_val[DET_W-1:0];
        end
        REG_CTRL: begin
          nxt.self_test = wr_val[CTRL_ST_BIT];
          nxt.scan_en   = wr_val[CTRL_SCAN_BIT];
          nxt.man_sel   = wr_val[CTRL_SEL_LSB +: 2];
        end
        REG_STAT: begin
          nxt.bresp = RESP_OKAY;
        end
        default: begin
          nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    // Ready drops while a write is held, so one write is in flight
    nxt.awready = !nxt.aw_have && !nxt.bvalid;
    nxt.wready  = !nxt.w_have && !nxt.bvalid;

    if (st.rvalid && S_AXI_RREADY) begin
      nxt.rvalid = 1'b0;
    end
    if (ar_hs) begin
      nxt.rvalid = 1'b1;
      nxt.rdata  = reg_word(st, reg_index(S_AXI_ARADDR));
      nxt.rresp  = (reg_index(S_AXI_ARADDR) == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    nxt.arready = !nxt.rvalid;

    // Code passes uninverted; the driver inverts, 0 gives full level
    nxt.dac_code = det_code[src_idx]; // [R2] [R3]
    nxt.dac_sel  = NSRC'(1) << src_idx; // [R3]
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st       <= '0;
      st.amp   <= {NSRC{AMP_RST}};
      st.det_x <= DET_RST;
      st.det_y <= DET_RST;
    end else begin
      st <= nxt;
    end
  end

  assign S_AXI_AWREADY = st.awready;
  assign S_AXI_WREADY  = st.wready;
  assign S_AXI_BRESP   = st.bresp;
  assign S_AXI_BVALID  = st.bvalid;
  assign S_AXI_ARREADY = st.arready;
  assign S_AXI_RDATA   = st.rdata;
  assign S_AXI_RRESP   = st.rresp;
  assign S_AXI_RVALID  = st.rvalid;
  assign DAC_CODE      = st.dac_code;
  assign DAC_SEL       = st.dac_sel;

  a_sel_onehot: assert property (@(posedge MCLK) disable iff (RST) // [R3]
    1'b1 |=> $onehot(DAC_SEL))
    else $error("select not one-hot");
  a_sel_matches: assert property (@(posedge MCLK) disable iff (RST) // [R3]
    1'b1 |=> DAC_SEL == (4'h1 << $past(src_idx)))
    else $error("select does not follow source");
  a_plain_code: assert property (@(posedge MCLK) disable iff (RST) // [R4]
    !st.self_test |=> DAC_CODE == $past(raw_sel))
    else $error("code altered outside self-test");
  a_x_zero_det: assert property (@(posedge MCLK) disable iff (RST) // [R7]
    st.self_test && !src_idx[1] && st.det_x[5:0] == 6'h00 |=> DAC_CODE == $past(raw_sel))
    else $error("X code used wrong setting");
  a_y_add_det: assert property (@(posedge MCLK) disable iff (RST) // [R7]
    st.self_test && src_idx[1] && st.det_y[6] && st.det_x[5:0] == 6'h00
    && 11'(raw_sel) + (11'(st.det_y[5:0]) << 3) <= 11'h3ff
    |=> 11'(DAC_CODE) == 11'($past(raw_sel)) + (11'($past(st.det_y[5:0])) << 3))
    else $error("Y code used wrong setting");
  a_amp_store: assert property (@(posedge MCLK) disable iff (RST) // [R1]
    wr_go && wr_idx == REG_Y_NEG |=> st.amp[3] == $past(wr_val[9:0]) && S_AXI_BVALID)
    else $error("amplitude write lost");
  a_bresp_hold: assert property (@(posedge MCLK) disable iff (RST)
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");

  // Bus side, one write and one read in flight
  a_rdata_hold: assert property (@(posedge MCLK) disable iff (RST)
    S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
    else $error("read data dropped");
  a_wr_blocked: assert property (@(posedge MCLK) disable iff (RST)
    S_AXI_BVALID
    |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while response pending");
  a_rd_blocked: assert property (@(posedge MCLK) disable iff (RST)
    S_AXI_RVALID
    |-> !S_AXI_ARREADY)
    else $error("read taken while data pending");
  a_b_follows: assert property (@(posedge MCLK) disable iff (RST)
    wr_go
    |=> S_AXI_BVALID)
    else $error("write response missing");
  a_r_follows: assert property (@(posedge MCLK) disable iff (RST)
    ar_hs
    |=> S_AXI_RVALID)
    else $error("read data missing");
  a_wr_unmapped: assert property (@(posedge MCLK) disable iff (RST)
    wr_go && wr_idx == REG_NONE
    |=> S_AXI_BRESP == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_rd_unmapped: assert property (@(posedge MCLK) disable iff (RST)
    ar_hs && reg_index(S_AXI_ARADDR) == REG_NONE
    |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  a_rd_mapped: assert property (@(posedge MCLK) disable iff (RST)
    ar_hs && reg_index(S_AXI_ARADDR) != REG_NONE
    |=> S_AXI_RRESP == RESP_OKAY)
    else $error("mapped read refused");

  // Stores and code path
  a_amp_any: assert property (@(posedge MCLK) disable iff (RST) // [R1]
    wr_go && wr_idx[3:2] == 2'b00
    |=> st.amp[$past(wr_idx[1:0])] == $past(wr_val[CODE_W-1:0]))
    else $error("amplitude not stored");
  a_xdet_store: assert property (@(posedge MCLK) disable iff (RST) // [R5]
    wr_go && wr_idx == REG_X_DET
    |=> st.det_x == $past(wr_val[DET_W-1:0]))
    else $error("X detune not stored");
  a_ydet_store: assert property (@(posedge MCLK) disable iff (RST) // [R7]
    wr_go && wr_idx == REG_Y_DET
    |=> st.det_y == $past(wr_val[DET_W-1:0]))
    else $error("Y detune not stored");
  a_st_store: assert property (@(posedge MCLK) disable iff (RST) // [R4]
    wr_go && wr_idx == REG_CTRL
    |=> st.self_test == $past(wr_val[CTRL_ST_BIT]))
    else $error("self-test select not stored");
  a_x_sub_det: assert property (@(posedge MCLK) disable iff (RST) // [R7]
    st.self_test && !src_idx[1] && !st.det_x[6] && 11'(raw_sel) >= (11'(st.det_x[5:0]) << 3)
    |=> 11'(DAC_CODE) + (11'($past(st.det_x[5:0])) << 3) == 11'($past(raw_sel)))
    else $error("X subtract used wrong setting");
  a_top_sat: assert property (@(posedge MCLK) disable iff (RST) // [R8]
    st.self_test && !src_idx[1] && st.det_x[6] && 11'(raw_sel) + (11'(st.det_x[5:0]) << 3) > 11'h3ff
    |=> DAC_CODE == CODE_MAX)
    else $error("code not clipped at top");
  a_floor_sat: assert property (@(posedge MCLK) disable iff (RST) // [R8]
    st.self_test && src_idx[1] && !st.det_y[6] && 11'(raw_sel) < (11'(st.det_y[5:0]) << 3)
    |=> DAC_CODE == 10'h000)
    else $error("code not clipped at zero");
  a_man_follow: assert property (@(posedge MCLK) disable iff (RST) // [R3]
    !st.scan_en
    |=> src_idx == $past(st.man_sel))
    else $error("manual source not followed");
  a_scan_step: assert property (@(posedge MCLK) disable iff (RST) // [R3]
    st.scan_en
    |=> src_idx == $past(src_idx) || src_idx == $past(src_idx) + 2'h1)
    else $error("scan skipped a source");

endmodule : xdc_dac_select
`default_nettype wire

//--- xdc_dac_model.sv
`timescale 1ns/1ps
`default_nettype none
module xdc_dac_model
  import xdc_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [CODE_W-1:0]            code,
  input  wire logic [NSRC-1:0]              sel,
  output logic      [NSRC-1:0][CODE_W-1:0] lvl,
  output int                                bad_sel
);
  logic rst_q;

  initial begin
    lvl     = '0;
    bad_sel = 0;
    rst_q   = 1'b1;
  end

  // Each driver output holds its last level until its source comes round again
  always @(posedge clk) begin
    rst_q <= rst;
    if (!rst && !rst_q && !$onehot(sel)) begin
      bad_sel <= bad_sel + 1;
    end
    for (int i = 0; i < NSRC; i++) begin
      if (sel[i]) begin
        lvl[i] <= CODE_MAX - code;
      end
    end
  end
endmodule : xdc_dac_model
`default_nettype wire

//--- test_excitation_dac_code_select.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module test_excitation_dac_code_select
  import xdc_pkg::*;
;
  logic                          clk, rst;
  logic [7:0]                    awaddr, araddr;
  logic                          awvalid, wvalid, bready, arvalid, rready;
  logic                          awready, wready, bvalid, arready, rvalid;
  logic [31:0]                   wdata, rdata, d;
  logic [1:0]                    bresp, rresp, r;
  logic [CODE_W-1:0]             dac_code, e;
  logic [NSRC-1:0]               dac_sel;
  logic [NSRC-1:0][CODE_W-1:0]   lvl;
  logic [CODE_W-1:0]             amp [4];
  logic [6:0]                    dets [3][2];
  int                            bad_sel, err_total, n_compared, cyc;

  xdc_dac_select u_dut (
    .MCLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .DAC_CODE(dac_code), .DAC_SEL(dac_sel)
  );

  xdc_dac_model u_dac (
    .clk(clk), .rst(rst), .code(dac_code), .sel(dac_sel), .lvl(lvl), .bad_sel(bad_sel)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        rs = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        v  = rdata;
        rs = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd

  // Clip rather than wrap, so a large detune cannot flip the drive polarity
  function automatic logic [CODE_W-1:0] exp_code(logic [9:0] a, logic [6:0] dt, logic st);
    int v;
    v = int'(a);
    if (st) v = dt[6] ? v + int'(dt[5:0]) * 8 : v - int'(dt[5:0]) * 8;
    if (v < 0) v = 0;
    if (v > 1023) v = 1023;
    return v[9:0];
  endfunction : exp_code

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  // Budget is generous: the whole sequence needs well under 2000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      $display("timeout waiting on the bus");
      finish_test;
    end
  end

  initial begin
    rst = 1'b1; awaddr = '0; araddr = '0; wdata = '0; cyc = 0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    err_total = 0; n_compared = 0;
    amp  = '{10'h3ff, 10'h000, 10'h155, 10'h2aa};
    dets = '{'{7'h41, 7'h3f}, '{7'h01, 7'h7f}, '{7'h00, 7'h45}};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), d, r);
      `CHK("reset value", 32'h0, d)
    end
    rd(8'h20, d, r);
    `CHK("unmapped read resp", RESP_SLVERR, r)
    wr(8'h20, 32'h1, r);
    `CHK("unmapped write resp", RESP_SLVERR, r)
    $display("test reset_and_map done");
    for (int i = 0; i < 4; i++) begin
      wr(8'(i * 4), {22'h3fffff, amp[i]}, r);
      rd(8'(i * 4), d, r);
      `CHK("amp readback", {22'h0, amp[i]}, d)
    end
    $display("test amp_codes done");
    for (int k = 0; k < 3; k++) begin
      wr(OFS_X_DET, {25'h0, dets[k][0]}, r);
      wr(OFS_Y_DET, {25'h0, dets[k][1]}, r);
      for (int st = 0; st < 2; st++) begin
        for (int s = 0; s < 4; s++) begin
          wr(OFS_CTRL, {28'h0, 2'(s), 1'b0, st[0]}, r);
          repeat (4) @(posedge clk);
          e = exp_code(amp[s], dets[k][s / 2], st[0]);
          `CHK("dac code", e, dac_code)
          `CHK("dac source", 4'(1 << s), dac_sel)
          `CHK("drive level", CODE_MAX - e, lvl[s])
          rd(OFS_STAT, d, r);
          `CHK("status word", {18'h0, 4'(1 << s), e}, d)
        end
      end
    end
    $display("test detune_select done");
    for (int i = 0; i < 4; i++) begin
      amp[i] = amp[i] ^ 10'h0f0;
      wr(8'(i * 4), {22'h0, amp[i]}, r);
    end
    wr(OFS_CTRL, 32'h3, r);
    repeat (80) @(posedge clk);
    for (int s = 0; s < 4; s++) begin
      `CHK("scan level", CODE_MAX - exp_code(amp[s], dets[2][s / 2], 1'b1), lvl[s])
    end
    `CHK("one hot select", 0, bad_sel)
    $display("test scan done");
    finish_test;
  end
endmodule : test_excitation_dac_code_select
`default_nettype wire
